// ---- src/accl_defs.vh ----
`ifndef ACCL_DEFS_VH
`define ACCL_DEFS_VH

// Register addresses on the plain register port
`define ACCL_ADDR_CTRL_STATUS   4'h0
`define ACCL_ADDR_SPECIAL_IO    4'h1
`define ACCL_ADDR_ROUTE_STATUS  4'h2
`define ACCL_ADDR_WIDTH         4

// Control/status register fields
`define ACCL_BIT_POWER_OFF      7
`define ACCL_BIT_BANDGAP_SEL    6
`define ACCL_BIT_SYNC_OUTPUT    5
`define ACCL_BIT_IRQ_FLAG       4
`define ACCL_BIT_IRQ_ENABLE     3
`define ACCL_BIT_CAPTURE_ROUTE  2
`define ACCL_BIT_MODE_HI        1
`define ACCL_BIT_MODE_LO        0

// Special-function register field
`define ACCL_BIT_MUX_ENABLE     3

// Route status register fields
`define ACCL_BIT_RS_NEG_LO      0
`define ACCL_BIT_RS_NEG_HI      2
`define ACCL_BIT_RS_NEG_MUXED   3
`define ACCL_BIT_RS_RAW         4
`define ACCL_BIT_RS_EVENT       5

// Interrupt mode encodings
`define ACCL_MODE_TOGGLE        2'h0
`define ACCL_MODE_RESERVED      2'h1
`define ACCL_MODE_FALLING       2'h2
`define ACCL_MODE_RISING        2'h3

// Reset values
`define ACCL_RST_CTRL           8'h00
`define ACCL_RST_SPECIAL_IO     8'h00
`define ACCL_RST_BYTE           8'h00
`define ACCL_NEG_SEL_PIN        4'h8

// Synchronizer depth in flip-flops
`define ACCL_SYNC_STAGES        2

`endif

// ---- src/accl_top.v ----
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "accl_defs.vh"
// Behaviour
// - output high when positive above negative
// - synchronize result, one to two cycles
// - mode field picks toggle, fall, rise
// - flag set on selected output event
// - flag cleared by vector or one
// - request needs flag, enable, global enable
// - disable bit seven powers comparator down
// - bit six picks bandgap as positive
// - bit two routes output to capture
// - mux enable, converter off selects channel
// - special register bit three is mux enable
// - control/status register bit layout
// - converter enable qualifies multiplexer use
module accl_top #(
  parameter LEVEL_W = 10
) (
  clk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  cmp_pos_pin,
  cmp_neg_pin,
  bandgap_level,
  converter_input_pins,
  converter_enable,
  channel_select_field,
  irq_ack,
  global_irq_enable,
  cmp_irq_request,
  capture_input,
  cmp_power_off,
  cmp_bandgap_select,
  cmp_neg_select,
  cmp_sync_output
);
  input  wire                          clk;
  input  wire                          nrst;
  input  wire [`ACCL_ADDR_WIDTH-1:0]   reg_addr;
  input  wire [7:0]                    reg_wdata;
  input  wire                          reg_wr;
  input  wire                          reg_rd;
  output reg  [7:0]                    reg_rdata;
  input  wire [LEVEL_W-1:0]            cmp_pos_pin;
  input  wire [LEVEL_W-1:0]            cmp_neg_pin;
  input  wire [LEVEL_W-1:0]            bandgap_level;
  input  wire [8*LEVEL_W-1:0]          converter_input_pins;
  input  wire                          converter_enable;
  input  wire [2:0]                    channel_select_field;
  input  wire                          irq_ack;
  input  wire                          global_irq_enable;
  output reg                           cmp_irq_request;
  output reg                           capture_input;
  output reg                           cmp_power_off;
  output reg                           cmp_bandgap_select;
  output reg  [3:0]                    cmp_neg_select;
  output reg                           cmp_sync_output;

  // Software-visible state
  reg                                  cmp_irq_flag;
  reg                                  cmp_irq_enable;
  reg                                  cmp_capture_route;
  reg  [1:0]                           cmp_irq_mode;
  reg  [7:0]                           special_function_io;

  // Synchronizer and edge detector
  reg                                  sync_first;
  reg                                  prev_output;
  reg                                  last_event;

  // Combinational terms
  reg  [LEVEL_W-1:0]                   pos_level;
  reg  [LEVEL_W-1:0]                   neg_level;
  reg                                  raw_result;
  reg                                  neg_muxed;
  reg                                  rise_evt;
  reg                                  fall_evt;
  reg                                  mode_evt;
  reg                                  ctrl_wr;
  reg                                  flag_w1c;
  reg                                  next_flag;
  reg  [7:0]                           next_rdata;
  reg  [7:0]                           ctrl_view;
  reg  [7:0]                           route_view;

  // Picks one channel's level out of the packed converter pin bus
  function [LEVEL_W-1:0] pick_channel;
    input [8*LEVEL_W-1:0] pins;
    input [2:0]           sel;
    integer               k;
    begin
      pick_channel = {LEVEL_W{1'b0}};
      for (k = 0; k < 8; k = k + 1) begin
        if (sel == k[2:0]) begin
          pick_channel = pins[k*LEVEL_W +: LEVEL_W];
        end
      end
    end
  endfunction

  // Multiplexer steering: the converter owns the mux while it is on
  always @* begin
    neg_muxed = special_function_io[`ACCL_BIT_MUX_ENABLE] & ~converter_enable;
    if (neg_muxed) begin
      neg_level = pick_channel(converter_input_pins, channel_select_field);
    end else begin
      neg_level = cmp_neg_pin;
    end
    if (cmp_bandgap_select) begin
      pos_level = bandgap_level;
    end else begin
      pos_level = cmp_pos_pin;
    end
  end

  // Comparison; a powered-down comparator reads low
  always @* begin
    raw_result = 1'b0;
    if (!cmp_power_off) begin
      raw_result = (pos_level > neg_level);
    end
  end

  // Event decode from the synchronized output
  always @* begin
    rise_evt = cmp_sync_output & ~prev_output;
    fall_evt = ~cmp_sync_output & prev_output;
    case (cmp_irq_mode)
      `ACCL_MODE_TOGGLE:   mode_evt = rise_evt | fall_evt;
      `ACCL_MODE_FALLING:  mode_evt = fall_evt;
      `ACCL_MODE_RISING:   mode_evt = rise_evt;
      `ACCL_MODE_RESERVED: mode_evt = 1'b0;
      default:             mode_evt = 1'b0;
    endcase
  end

  // Flag update: a new event wins over a clear in the same cycle
  always @* begin
    ctrl_wr   = reg_wr & (reg_addr == `ACCL_ADDR_CTRL_STATUS);
    flag_w1c  = ctrl_wr & reg_wdata[`ACCL_BIT_IRQ_FLAG];
    next_flag = cmp_irq_flag;
    if (flag_w1c || irq_ack) begin
      next_flag = 1'b0;
    end
    if (mode_evt) begin
      next_flag = 1'b1;
    end
  end

  // Read views
  always @* begin
    ctrl_view = {cmp_power_off,
                 cmp_bandgap_select,
                 cmp_sync_output,
                 cmp_irq_flag,
                 cmp_irq_enable,
                 cmp_capture_route,
                 cmp_irq_mode};
    route_view = `ACCL_RST_BYTE;
    route_view[`ACCL_BIT_RS_NEG_HI:`ACCL_BIT_RS_NEG_LO] = channel_select_field;
    route_view[`ACCL_BIT_RS_NEG_MUXED] = neg_muxed;
    route_view[`ACCL_BIT_RS_RAW]       = raw_result;
    route_view[`ACCL_BIT_RS_EVENT]     = last_event;
    case (reg_addr)
      `ACCL_ADDR_CTRL_STATUS:  next_rdata = ctrl_view;
      `ACCL_ADDR_SPECIAL_IO:   next_rdata = special_function_io;
      `ACCL_ADDR_ROUTE_STATUS: next_rdata = route_view;
      default:                 next_rdata = `ACCL_RST_BYTE;
    endcase
  end

  // Control register writes
  always @(posedge clk) begin
    if (!nrst) begin
      cmp_power_off      <= 1'b0;
      cmp_bandgap_select <= 1'b0;
      cmp_irq_enable     <= 1'b0;
      cmp_capture_route  <= 1'b0;
      cmp_irq_mode       <= `ACCL_MODE_TOGGLE;
      cmp_irq_flag       <= 1'b0;
    end else begin
      cmp_irq_flag <= next_flag;
      if (ctrl_wr) begin
        // Sync output bit is read-only and the flag is write-one-to-clear
        cmp_power_off      <= reg_wdata[`ACCL_BIT_POWER_OFF];
        cmp_bandgap_select <= reg_wdata[`ACCL_BIT_BANDGAP_SEL];
        cmp_irq_enable     <= reg_wdata[`ACCL_BIT_IRQ_ENABLE];
        cmp_capture_route  <= reg_wdata[`ACCL_BIT_CAPTURE_ROUTE];
        cmp_irq_mode       <= reg_wdata[`ACCL_BIT_MODE_HI:`ACCL_BIT_MODE_LO];
      end
    end
  end

  // Shared special-function register; only the mux enable bit is used here
  always @(posedge clk) begin
    if (!nrst) begin
      special_function_io <= `ACCL_RST_SPECIAL_IO;
    end else if (reg_wr && (reg_addr == `ACCL_ADDR_SPECIAL_IO)) begin
      special_function_io <= reg_wdata;
    end
  end

  // Two-flop synchronizer; the first stage feeds nothing but the second
  always @(posedge clk) begin
    if (!nrst) begin
      sync_first      <= 1'b0;
      cmp_sync_output <= 1'b0;
      prev_output     <= 1'b0;
      last_event      <= 1'b0;
    end else begin
      sync_first      <= raw_result;
      cmp_sync_output <= sync_first;
      prev_output     <= cmp_sync_output;
      last_event      <= mode_evt;
    end
  end

  // Request, capture route and read port outputs
  always @(posedge clk) begin
    if (!nrst) begin
      cmp_irq_request <= 1'b0;
      capture_input   <= 1'b0;
      cmp_neg_select  <= `ACCL_NEG_SEL_PIN;
      reg_rdata       <= `ACCL_RST_BYTE;
    end else begin
      // Taken from next_flag so an acked flag drops the request at once
      cmp_irq_request <= next_flag & cmp_irq_enable & global_irq_enable;
      // Timer's own noise canceler and edge select act on this level
      capture_input   <= cmp_capture_route & cmp_sync_output;
      cmp_neg_select  <= neg_muxed ? {1'b0, channel_select_field} : `ACCL_NEG_SEL_PIN;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end else begin
        reg_rdata <= `ACCL_RST_BYTE;
      end
    end
  end

endmodule // accl_top

// ---- test/accl_far.sv ----
`timescale 1ns/1ps
module accl_far #(
  parameter CAP_IRQ_EN = 1
) (
  input  wire         clk,
  input  wire         capture_input,
  output logic [9:0]  cmp_pos_pin,
  output logic [9:0]  cmp_neg_pin,
  output wire  [9:0]  bandgap_level,
  output wire  [79:0] converter_input_pins,
  output logic [7:0]  capture_count
);
  logic cap_prev = 1'b0;
  initial begin
    cmp_pos_pin = 10'h000;
    cmp_neg_pin = 10'h100;
    capture_count = 8'h00;
  end
  assign bandgap_level = 10'h200;
  // Channel k sits at k*128 so every mux choice gives a distinct level
  for (genvar k = 0; k < 8; k++) begin : g_chan
    assign converter_input_pins[k*10 +: 10] = 10'(k * 128);
  end
  // Timer front end counts rising edges, only with its capture irq enabled
  always @(posedge clk) begin
    cap_prev <= capture_input;
    if (CAP_IRQ_EN != 0 && capture_input && !cap_prev)
      capture_count <= capture_count + 8'h01;
  end
  task automatic drive(input logic [9:0] p, input logic [9:0] n);
    @(posedge clk);
    cmp_pos_pin <= p;
    cmp_neg_pin <= n;
  endtask
endmodule // accl_far

// ---- test/accl_chk.sv ----
`timescale 1ns/1ps
module accl_chk (
  input wire       clk,
  input wire       nrst,
  input wire [3:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       converter_enable,
  input wire [2:0] channel_select_field,
  input wire       irq_ack,
  input wire       global_irq_enable,
  input wire       cmp_irq_request,
  input wire       capture_input,
  input wire       cmp_power_off,
  input wire       cmp_bandgap_select,
  input wire [3:0] cmp_neg_select,
  input wire       cmp_sync_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_NEG_CHAN: assert property (!cmp_neg_select[3] |->
    cmp_neg_select[2:0] == $past(channel_select_field)) else $error("channel wrong");
  AST_NEG_PIN: assert property ($past(converter_enable) |-> cmp_neg_select == 4'h8)
    else $error("mux used while converter on");
  AST_CAPTURE: assert property (capture_input |-> $past(cmp_sync_output))
    else $error("capture wrong");
  AST_POWER: assert property ($past(cmp_power_off, 2) |-> !cmp_sync_output)
    else $error("output while off");
  AST_REQUEST: assert property (cmp_irq_request |-> $past(global_irq_enable))
    else $error("request wrong");
  AST_ACK: assert property (irq_ack && $stable(cmp_sync_output) |=> !cmp_irq_request)
    else $error("ack ignored");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata not idle");
  AST_RD_CTRL: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |->
    reg_rdata[7:5] == {$past(cmp_power_off), $past(cmp_bandgap_select), $past(cmp_sync_output)})
    else $error("ctrl read wrong");
  cover property ($rose(cmp_irq_request));
  cover property ($rose(capture_input));
  cover property (!cmp_neg_select[3]);
endmodule // accl_chk
bind accl_top accl_chk accl_chk_inst (.*);

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_ack = 1'b0;
  logic        converter_enable = 1'b0, global_irq_enable = 1'b0, e;
  logic [3:0]  reg_addr = 4'h0, r;
  logic [7:0]  reg_wdata = 8'h00, got, c;
  logic [2:0]  channel_select_field = 3'h0;
  logic [9:0]  p, n;
  wire  [9:0]  cmp_pos_pin, cmp_neg_pin, bandgap_level;
  wire  [79:0] converter_input_pins;
  wire  [7:0]  reg_rdata, capture_count;
  wire         cmp_irq_request, capture_input;
  integer      failures = 0, n_compared = 0, seed = 2, m;
  always #2.5 clk = ~clk;
  accl_top accl_top_inst (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmp_pos_pin, .cmp_neg_pin, .bandgap_level, .converter_input_pins, .converter_enable,
    .channel_select_field, .irq_ack, .global_irq_enable, .cmp_irq_request, .capture_input,
    .cmp_power_off(), .cmp_bandgap_select(), .cmp_neg_select(), .cmp_sync_output());
  accl_far accl_far_inst (.clk, .capture_input, .cmp_pos_pin, .cmp_neg_pin, .bandgap_level,
    .converter_input_pins, .capture_count);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared = n_compared + 1;
    if (g !== x) begin
      failures = failures + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Expected comparator result from levels, controls and the mux choice
  function automatic logic exp_raw(input logic [7:0] cc, input logic [3:0] rr,
                                   input logic [9:0] pp, input logic [9:0] nn);
    return !cc[7] && ((cc[6] ? 10'h200 : pp) > (rr[3] ? nn : 10'(rr[2:0] * 128)));
  endfunction
  task automatic complete_run;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(4'h0, got);
    chk(got, 8'h00);
    rd(4'h1, got);
    chk(got, 8'h00);
    rd(4'h7, got);
    chk(got, 8'h00);
    for (m = 0; m < 4; m++) begin
      global_irq_enable <= (m != 0);
      wr(4'h0, 8'h00); // Interrupt off before the mode change
      wr(4'h0, {6'h00, m[1:0]});
      wr(4'h0, {6'h06, m[1:0]});
      accl_far_inst.drive(10'h300, 10'h100);
      repeat (4) @(posedge clk);
      e = (m == 0 || m == 3);
      rd(4'h0, got);
      chk(got, {3'b001, e, 2'b10, m[1:0]});
      chk({7'h00, cmp_irq_request}, {7'h00, e && m != 0});
      wr(4'h0, {6'h06, m[1:0]});
      accl_far_inst.drive(10'h000, 10'h100);
      repeat (4) @(posedge clk);
      e = (m == 0 || m == 2);
      rd(4'h0, got);
      chk(got, {3'b000, e, 2'b10, m[1:0]});
      if (m == 2) begin
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        rd(4'h0, got);
        chk(got, 8'h0a);
        chk({7'h00, cmp_irq_request}, 8'h00);
      end
    end
    wr(4'h0, 8'h00);
    chk(capture_count, 8'h00);
    wr(4'h0, 8'h04);
    accl_far_inst.drive(10'h300, 10'h100);
    repeat (4) @(posedge clk);
    accl_far_inst.drive(10'h000, 10'h100);
    repeat (4) @(posedge clk);
    chk(capture_count, 8'h01);
    wr(4'h1, 8'h08);
    for (m = 0; m < 24; m++) begin
      c = 8'($random(seed)) & 8'hc0; // Enable stays clear while power changes
      r = 4'($random(seed));
      p = 10'($random(seed));
      n = (m == 0) ? p : 10'($random(seed));
      converter_enable <= r[3];
      channel_select_field <= r[2:0];
      wr(4'h0, c);
      accl_far_inst.drive(p, n);
      repeat (4) @(posedge clk);
      e = exp_raw(c, r, p, n);
      rd(4'h2, got);
      chk(got & 8'h1f, {3'h0, e, !r[3], r[2:0]});
      rd(4'h0, got);
      chk(got & 8'he0, {c[7:6], e, 5'h00});
    end
    complete_run;
  end
  initial begin
    #200000;
    failures = failures + 1;
    complete_run;
  end
endmodule // tb
